// ---- design/compact_decode_pkg.sv ----
package compact_decode_pkg;

	// ------------------------------------------------------------------
	// datapath sizes and reset values
	// ------------------------------------------------------------------
	localparam int          REG_WIDTH   = 32;
	localparam int          LOW_REGS    = 8;
	localparam logic [31:0] REG_RESET   = 32'h0000_0000;
	localparam logic [3:0]  FLAGS_RESET = 4'h0;

	// ------------------------------------------------------------------
	// flag positions inside status_flags_word
	// ------------------------------------------------------------------
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 0;

	// ------------------------------------------------------------------
	// format identification
	// ------------------------------------------------------------------
	localparam logic [2:0] SHIFT_TAG  = 3'h0;
	localparam logic [4:0] ADDSUB_TAG = 5'h03;
	localparam logic [2:0] BYTEOP_TAG = 3'h1;

	// ------------------------------------------------------------------
	// field positions within the halfword
	// ------------------------------------------------------------------
	localparam int TAG_HI    = 15;
	localparam int TAG3_LO   = 13;
	localparam int TAG5_LO   = 11;
	localparam int OP_HI     = 12;
	localparam int OP_LO     = 11;
	localparam int SHAMT_HI  = 10;
	localparam int SHAMT_LO  = 6;
	localparam int SRC_HI    = 5;
	localparam int SRC_LO    = 3;
	localparam int DST_HI    = 2;
	localparam int DST_LO    = 0;
	localparam int ITYPE_BIT = 10;
	localparam int SUBOP_BIT = 9;
	localparam int SECOND_HI = 8;
	localparam int SECOND_LO = 6;
	localparam int BREG_HI   = 10;
	localparam int BREG_LO   = 8;
	localparam int BYTE_HI   = 7;
	localparam int BYTE_LO   = 0;

	// ------------------------------------------------------------------
	// operation codes
	// ------------------------------------------------------------------
	localparam logic [1:0] SH_LEFT  = 2'h0;
	localparam logic [1:0] SH_RIGHT = 2'h1;
	localparam logic [1:0] SH_SIGN  = 2'h2;
	localparam logic [1:0] SH_NONE  = 2'h3;
	localparam logic [1:0] BY_MOVE  = 2'h0;
	localparam logic [1:0] BY_CMP   = 2'h1;
	localparam logic [1:0] BY_ADD   = 2'h2;
	localparam logic [1:0] BY_SUB   = 2'h3;

	// ------------------------------------------------------------------
	// timing: every decoded op retires this many cycles after acceptance
	// ------------------------------------------------------------------
	localparam int EXEC_CYCLES = 1;

	typedef enum logic [2:0] {
		KIND_MOVE = 3'h0,
		KIND_SHL  = 3'h1,
		KIND_SHR  = 3'h2,
		KIND_SAR  = 3'h3,
		KIND_ADD  = 3'h4,
		KIND_SUB  = 3'h5
	} alu_kind_e;

endpackage

// ---- design/alu_bus_if.sv ----
`timescale 1ns/10ps
interface alu_bus_if;
	logic [31:0]                  opA;
	logic [31:0]                  opB;
	logic [4:0]                   amount;
	compact_decode_pkg::alu_kind_e kind;
	logic [3:0]                   flagsIn;
	logic [31:0]                  result;
	logic [3:0]                   flagsOut;

	modport alu  (input opA, opB, amount, kind, flagsIn, output result, flagsOut);
	modport core (output opA, opB, amount, kind, flagsIn, input result, flagsOut);
endinterface

// ---- design/compact_alu.sv ----
`timescale 1ns/10ps
module compact_alu (
	alu_bus_if.alu bus
);

	// ------------------------------------------------------------------
	// shifter and adder with flag generation
	// ------------------------------------------------------------------
	logic [32:0] wide;
	logic [31:0] res;
	logic        carry;
	logic        ovf;
	logic [5:0]  leftIdx;
	logic [4:0]  rightIdx;

	// amount 0 on right shifts encodes a shift by 32
	always_comb begin
		wide     = 33'h0_0000_0000;
		res      = bus.opA;
		carry    = bus.flagsIn[compact_decode_pkg::FLAG_C];
		ovf      = bus.flagsIn[compact_decode_pkg::FLAG_V];
		leftIdx  = 6'h20 - {1'b0, bus.amount};
		rightIdx = bus.amount - 5'h01;
		unique case (bus.kind)
			compact_decode_pkg::KIND_MOVE: begin
				res = bus.opB;
			end
			compact_decode_pkg::KIND_SHL: begin
				res = bus.opA << bus.amount;
				if (bus.amount != 5'h00) begin
					carry = bus.opA[leftIdx[4:0]];
				end
			end
			compact_decode_pkg::KIND_SHR: begin
				if (bus.amount == 5'h00) begin
					res   = 32'h0000_0000;
					carry = bus.opA[31];
				end else begin
					res   = bus.opA >> bus.amount;
					carry = bus.opA[rightIdx];
				end
			end
			compact_decode_pkg::KIND_SAR: begin
				if (bus.amount == 5'h00) begin
					res   = {32{bus.opA[31]}};
					carry = bus.opA[31];
				end else begin
					res   = 32'($signed(bus.opA) >>> bus.amount);
					carry = bus.opA[rightIdx];
				end
			end
			compact_decode_pkg::KIND_ADD: begin
				wide  = {1'b0, bus.opA} + {1'b0, bus.opB};
				res   = wide[31:0];
				carry = wide[32];
				ovf   = (bus.opA[31] == bus.opB[31]) && (res[31] != bus.opA[31]);
			end
			compact_decode_pkg::KIND_SUB: begin
				// carry is the inverted borrow
				wide  = {1'b0, bus.opA} + {1'b0, ~bus.opB} + 33'h0_0000_0001;
				res   = wide[31:0];
				carry = wide[32];
				ovf   = (bus.opA[31] != bus.opB[31]) && (res[31] != bus.opA[31]);
			end
			default: begin
				res = bus.opA;
			end
		endcase
		bus.result   = res;
		bus.flagsOut = {res[31], (res == 32'h0000_0000), carry, ovf};
	end

endmodule

// ---- design/compact_isa_shift_addsub_decode.sv ----
`timescale 1ns/10ps
module compact_isa_shift_addsub_decode (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         instrValid,
	input  wire logic [15:0]  instr,
	input  wire logic         loadEn,
	input  wire logic [2:0]   loadIdx,
	input  wire logic [31:0]  loadData,
	output logic              regWriteEn,
	output logic [2:0]        regWriteIdx,
	output logic [31:0]       regWriteData,
	output logic [3:0]        statusFlagsWord,
	output logic              instrDone,
	output logic              instrUnsupported,
	output logic [255:0]      lowRegsFlat
);

	// ------------------------------------------------------------------
	// field extraction and format decode
	// ------------------------------------------------------------------
	logic [31:0] lowReg [compact_decode_pkg::LOW_REGS];
	logic [1:0]  opField;
	logic [4:0]  shiftAmountImm;
	logic [2:0]  sourceRegField;
	logic [2:0]  destRegField;
	logic [2:0]  secondOperandReg;
	logic [2:0]  byteRegField;
	logic [7:0]  byteImm;
	logic        isShift;
	logic        isAddSub;
	logic        isByteOp;
	logic        fire;

	// fields overlap; each format reads only its own
	assign opField          = instr[compact_decode_pkg::OP_HI:compact_decode_pkg::OP_LO];
	assign shiftAmountImm   = instr[compact_decode_pkg::SHAMT_HI:compact_decode_pkg::SHAMT_LO];
	assign sourceRegField   = instr[compact_decode_pkg::SRC_HI:compact_decode_pkg::SRC_LO];
	assign destRegField     = instr[compact_decode_pkg::DST_HI:compact_decode_pkg::DST_LO];
	assign secondOperandReg = instr[compact_decode_pkg::SECOND_HI:compact_decode_pkg::SECOND_LO];
	assign byteRegField     = instr[compact_decode_pkg::BREG_HI:compact_decode_pkg::BREG_LO];
	assign byteImm          = instr[compact_decode_pkg::BYTE_HI:compact_decode_pkg::BYTE_LO];

	// format tags
	assign isShift  = (instr[compact_decode_pkg::TAG_HI:compact_decode_pkg::TAG3_LO]
	                   == compact_decode_pkg::SHIFT_TAG)
	                  && (opField != compact_decode_pkg::SH_NONE);
	assign isAddSub = (instr[compact_decode_pkg::TAG_HI:compact_decode_pkg::TAG5_LO]
	                   == compact_decode_pkg::ADDSUB_TAG);
	assign isByteOp = (instr[compact_decode_pkg::TAG_HI:compact_decode_pkg::TAG3_LO]
	                   == compact_decode_pkg::BYTEOP_TAG);
	assign fire     = instrValid;

	// ------------------------------------------------------------------
	// operand steering into the shared alu
	// ------------------------------------------------------------------
	alu_bus_if aluBus ();

	compact_alu aluUnit (
		.bus (aluBus.alu)
	);

	// three-bit register fields can only ever reach r0..r7
	always_comb begin
		aluBus.opA     = lowReg[sourceRegField];
		aluBus.opB     = lowReg[secondOperandReg];
		aluBus.amount  = shiftAmountImm;
		aluBus.kind    = compact_decode_pkg::KIND_MOVE;
		aluBus.flagsIn = statusFlagsWord;
		if (isShift) begin
			unique case (opField)
				compact_decode_pkg::SH_LEFT:  aluBus.kind = compact_decode_pkg::KIND_SHL;
				compact_decode_pkg::SH_RIGHT: aluBus.kind = compact_decode_pkg::KIND_SHR;
				default:                      aluBus.kind = compact_decode_pkg::KIND_SAR;
			endcase
		end else if (isAddSub) begin
			if (instr[compact_decode_pkg::ITYPE_BIT]) begin
				aluBus.opB = {29'h0000_0000, secondOperandReg};
			end
			aluBus.kind = instr[compact_decode_pkg::SUBOP_BIT]
			              ? compact_decode_pkg::KIND_SUB : compact_decode_pkg::KIND_ADD;
		end else if (isByteOp) begin
			aluBus.opA = lowReg[byteRegField];
			aluBus.opB = {24'h00_0000, byteImm};
			unique case (opField)
				compact_decode_pkg::BY_MOVE: aluBus.kind = compact_decode_pkg::KIND_MOVE;
				compact_decode_pkg::BY_ADD:  aluBus.kind = compact_decode_pkg::KIND_ADD;
				default:                     aluBus.kind = compact_decode_pkg::KIND_SUB;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// register file and write-back, one cycle per instruction
	// ------------------------------------------------------------------
	logic       writes;
	logic [2:0] writeIdx;

	assign writes   = fire && (isShift || isAddSub
	                  || (isByteOp && opField != compact_decode_pkg::BY_CMP));
	assign writeIdx = isByteOp ? byteRegField : destRegField;

	// an instruction in the same cycle as a load takes the port; load is dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < compact_decode_pkg::LOW_REGS; i++) begin
				lowReg[i] <= compact_decode_pkg::REG_RESET;
			end
		end else if (writes) begin
			lowReg[writeIdx] <= aluBus.result;
		end else if (loadEn && !fire) begin
			lowReg[loadIdx] <= loadData;
		end
	end

	// write-back report to the datapath
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regWriteEn   <= 1'b0;
			regWriteIdx  <= 3'h0;
			regWriteData <= compact_decode_pkg::REG_RESET;
		end else begin
			regWriteEn   <= writes;
			regWriteIdx  <= writeIdx;
			regWriteData <= aluBus.result;
		end
	end

	// flags change only for the three decoded formats; all else holds them
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			statusFlagsWord <= compact_decode_pkg::FLAGS_RESET;
		end else if (fire && (isShift || isAddSub || isByteOp)) begin
			statusFlagsWord <= aluBus.flagsOut;
		end
	end

	// retire and reject pulses
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			instrDone        <= 1'b0;
			instrUnsupported <= 1'b0;
		end else begin
			instrDone        <= fire && (isShift || isAddSub || isByteOp);
			instrUnsupported <= fire && !(isShift || isAddSub || isByteOp);
		end
	end

	// register view for the datapath, registered like every other output
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lowRegsFlat <= '0;
		end else begin
			for (int i = 0; i < compact_decode_pkg::LOW_REGS; i++) begin
				lowRegsFlat[i*32 +: 32] <= lowReg[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// reference values for checks
	// ------------------------------------------------------------------
	logic [31:0] refSrc;
	logic [31:0] refSecond;
	logic [31:0] refByteReg;
	logic [31:0] refLeft;
	logic [31:0] refRight;
	logic [31:0] refSign;
	logic [31:0] refSmall;
	logic        refCmpZero;

	assign refSrc     = lowReg[sourceRegField];
	assign refSecond  = lowReg[secondOperandReg];
	assign refByteReg = lowReg[byteRegField];
	assign refSmall   = {29'h0000_0000, secondOperandReg};
	assign refLeft    = refSrc << shiftAmountImm;
	assign refRight   = (shiftAmountImm == 5'h00) ? 32'h0000_0000 : (refSrc >> shiftAmountImm);
	assign refSign    = (shiftAmountImm == 5'h00) ? {32{refSrc[31]}}
	                    : 32'($signed(refSrc) >>> shiftAmountImm);
	assign refCmpZero = (refByteReg == {24'h00_0000, byteImm});

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	chk_shift_left: assert property (@(posedge clock) disable iff (rst)
		fire && isShift && opField == compact_decode_pkg::SH_LEFT
		|=> regWriteEn && regWriteData == $past(refLeft))
		else $error("left shift result wrong");

	chk_shift_right: assert property (@(posedge clock) disable iff (rst)
		fire && isShift && opField == compact_decode_pkg::SH_RIGHT
		|=> regWriteData == $past(refRight))
		else $error("logical right shift result wrong");

	chk_shift_sign: assert property (@(posedge clock) disable iff (rst)
		fire && isShift && opField == compact_decode_pkg::SH_SIGN
		|=> regWriteData == $past(refSign))
		else $error("sign-fill shift result wrong");

	chk_shift_dest: assert property (@(posedge clock) disable iff (rst)
		fire && (isShift || isAddSub) |=> regWriteIdx == $past(destRegField))
		else $error("shift destination not the low field");

	chk_flags_nz: assert property (@(posedge clock) disable iff (rst)
		fire && (isShift || isAddSub) |=> statusFlagsWord[compact_decode_pkg::FLAG_N]
		== regWriteData[31] && statusFlagsWord[compact_decode_pkg::FLAG_Z]
		== (regWriteData == 32'h0000_0000))
		else $error("negative or zero flag wrong");

	chk_add_reg: assert property (@(posedge clock) disable iff (rst)
		fire && isAddSub && instr[10:9] == 2'h0
		|=> regWriteData == $past(refSrc) + $past(refSecond))
		else $error("register add wrong");

	chk_add_imm: assert property (@(posedge clock) disable iff (rst)
		fire && isAddSub && instr[10:9] == 2'h2
		|=> regWriteData == $past(refSrc) + $past(refSmall))
		else $error("immediate add wrong");

	chk_sub_reg: assert property (@(posedge clock) disable iff (rst)
		fire && isAddSub && instr[10:9] == 2'h1
		|=> regWriteData == $past(refSrc) - $past(refSecond))
		else $error("register subtract wrong");

	chk_sub_imm: assert property (@(posedge clock) disable iff (rst)
		fire && isAddSub && instr[10:9] == 2'h3
		|=> regWriteData == $past(refSrc) - $past(refSmall))
		else $error("immediate subtract wrong");

	chk_byte_dest: assert property (@(posedge clock) disable iff (rst)
		fire && isByteOp |=> regWriteIdx == $past(byteRegField))
		else $error("byte form destination wrong");

	chk_one_cycle: assert property (@(posedge clock) disable iff (rst)
		fire && (isShift || isAddSub || isByteOp) |=> instrDone ##1 !instrDone || $past(fire))
		else $error("retire not one cycle after acceptance");

	chk_flags_held: assert property (@(posedge clock) disable iff (rst)
		fire && !(isShift || isAddSub || isByteOp)
		|=> $stable(statusFlagsWord) && !regWriteEn && instrUnsupported)
		else $error("undecoded form touched flags or registers");

	chk_move_byte: assert property (@(posedge clock) disable iff (rst)
		fire && isByteOp && opField == compact_decode_pkg::BY_MOVE
		|=> regWriteEn && regWriteData == {24'h00_0000, $past(byteImm)})
		else $error("byte move wrong");

	chk_cmp_nowrite: assert property (@(posedge clock) disable iff (rst)
		fire && isByteOp && opField == compact_decode_pkg::BY_CMP
		|=> !regWriteEn && statusFlagsWord[compact_decode_pkg::FLAG_Z] == $past(refCmpZero))
		else $error("compare wrote a register or set zero wrongly");

endmodule

// ---- verification/fetch_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// fetch stage and preload side of the core datapath
// ------------------------------------------------------------------
module fetch_model (
	input  wire logic        clock,
	output logic             instrValid,
	output logic [15:0]      instr,
	output logic             loadEn,
	output logic [2:0]       loadIdx,
	output logic [31:0]      loadData
);
	// idle lines at time zero
	initial begin
		instrValid = 1'b0;
		instr      = 16'hffff;
		loadEn     = 1'b0;
		loadIdx    = 3'h0;
		loadData   = 32'h0000_0000;
	end

	// present one halfword; a later present keeps valid up back to back
	task automatic present(input logic [15:0] h);
		@(posedge clock);
		instrValid <= 1'b1;
		instr      <= h;
	endtask

	// release: stale halfword is inverted so it cannot pass for a hold
	task automatic idle();
		@(posedge clock);
		instrValid <= 1'b0;
		instr      <= ~instr;
	endtask

	// preload one low register, taken at the next edge
	task automatic preload(input logic [2:0] idx, input logic [31:0] d);
		@(posedge clock);
		loadEn   <= 1'b1;
		loadIdx  <= idx;
		loadData <= d;
		@(posedge clock);
		loadEn   <= 1'b0;
		loadData <= ~d;
	endtask

	// instruction and preload in one cycle; the preload must be dropped
	task automatic presentWithLoad(input logic [15:0] h, input logic [2:0] idx,
		input logic [31:0] d);
		@(posedge clock);
		instrValid <= 1'b1;
		instr      <= h;
		loadEn     <= 1'b1;
		loadIdx    <= idx;
		loadData   <= d;
		@(posedge clock);
		instrValid <= 1'b0;
		instr      <= ~h;
		loadEn     <= 1'b0;
		loadData   <= ~d;
	endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic          clock;
	logic          rst;
	logic          instrValid;
	logic [15:0]   instr;
	logic          loadEn;
	logic [2:0]    loadIdx;
	logic [31:0]   loadData;
	logic          regWriteEn;
	logic [2:0]    regWriteIdx;
	logic [31:0]   regWriteData;
	logic [3:0]    statusFlagsWord;
	logic          instrDone;
	logic          instrUnsupported;
	logic [255:0]  lowRegsFlat;
	logic [31:0]   shadow [8];
	logic [3:0]    shadowFlags;
	int            n_errors;
	int            check_count;

	compact_isa_shift_addsub_decode i_compact_isa_shift_addsub_decode (
		.clock(clock), .rst(rst), .instrValid(instrValid), .instr(instr),
		.loadEn(loadEn), .loadIdx(loadIdx), .loadData(loadData),
		.regWriteEn(regWriteEn), .regWriteIdx(regWriteIdx), .regWriteData(regWriteData),
		.statusFlagsWord(statusFlagsWord), .instrDone(instrDone),
		.instrUnsupported(instrUnsupported), .lowRegsFlat(lowRegsFlat));

	fetch_model i_fetch_model (
		.clock(clock), .instrValid(instrValid), .instr(instr),
		.loadEn(loadEn), .loadIdx(loadIdx), .loadData(loadData));

	// ------------------------------------------------------------------
	// clock, reset and helpers
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask

	// field packers for the three formats
	function automatic logic [15:0] f1(logic [1:0] op, logic [4:0] n, logic [2:0] s, logic [2:0] d);
		return {3'b000, op, n, s, d};
	endfunction
	function automatic logic [15:0] f2(logic i, logic op, logic [2:0] n, logic [2:0] s,
		logic [2:0] d);
		return {5'b00011, i, op, n, s, d};
	endfunction
	function automatic logic [15:0] f3(logic [1:0] op, logic [2:0] r, logic [7:0] imm);
		return {3'b001, op, r, imm};
	endfunction

	// add or subtract with flags {N,Z,C,V}; carry is carry out, not borrow
	function automatic void arith(input logic [31:0] a, input logic [31:0] b, input logic sub,
		output logic [31:0] res, inout logic [3:0] fl);
		logic [31:0] bb;
		logic [32:0] sum;
		bb  = sub ? ~b : b;
		sum = {1'b0, a} + {1'b0, bb} + {32'h0, sub};
		res = sum[31:0];
		fl  = {res[31], res == 32'h0, sum[32], (a[31] == bb[31]) && (res[31] != a[31])};
	endfunction

	// expected outcome of one halfword against the shadow state
	function automatic void refExec(input logic [15:0] h, output logic [31:0] res,
		output logic [3:0] fl, output logic wr, output logic ok, output logic [2:0] dst);
		logic [31:0] a;
		logic [31:0] b;
		int          n;
		fl  = shadowFlags;
		res = 32'h0;
		wr  = 1'b1;
		ok  = 1'b1;
		dst = h[2:0];
		n   = int'(h[10:6]);
		a   = shadow[h[5:3]];
		b   = h[10] ? {29'h0, h[8:6]} : shadow[h[8:6]];
		if (h[15:11] == 5'b00011) begin
			arith(a, b, h[9], res, fl);
		end else if (h[15:13] == 3'b000) begin
			if (h[12:11] == 2'b00) begin
				res = a << n;
				if (n != 0) fl[1] = a[32 - n];
			end else if (n == 0) begin
				res   = (h[12:11] == 2'b01) ? 32'h0 : {32{a[31]}};
				fl[1] = a[31];
			end else begin
				res   = (h[12:11] == 2'b01) ? a >> n : 32'($signed(a) >>> n);
				fl[1] = a[n - 1];
			end
			fl[3:2] = {res[31], res == 32'h0};
		end else if (h[15:13] == 3'b001) begin
			dst = h[10:8];
			a   = shadow[dst];
			b   = {24'h0, h[7:0]};
			wr  = (h[12:11] != 2'b01);
			if (h[12:11] == 2'b00) begin
				res     = b;
				fl[3:2] = {res[31], res == 32'h0};
			end else begin
				arith(a, b, h[12:11] != 2'b10, res, fl);
			end
		end else begin
			ok = 1'b0;
			wr = 1'b0;
		end
	endfunction

	// judge the cycle right after the accepting edge
	task automatic checkResult(input logic [15:0] h);
		logic [31:0] res;
		logic [3:0]  fl;
		logic        wr;
		logic        ok;
		logic [2:0]  dst;
		refExec(h, res, fl, wr, ok, dst);
		@(negedge clock);
		compare("instrDone", 32'(ok), 32'(instrDone));
		compare("instrUnsupported", 32'(!ok), 32'(instrUnsupported));
		compare("regWriteEn", 32'(wr), 32'(regWriteEn));
		if (wr) begin
			compare("regWriteIdx", 32'(dst), 32'(regWriteIdx));
			compare("regWriteData", res, regWriteData);
			shadow[dst] = res;
		end
		compare("statusFlagsWord", 32'(fl), 32'(statusFlagsWord));
		shadowFlags = fl;
	endtask

	// register copy lags one cycle behind the write
	task automatic checkFlat();
		@(negedge clock);
		for (int i = 0; i < 8; i++) begin
			compare("lowRegsFlat", shadow[i], lowRegsFlat[32*i +: 32]);
		end
	endtask

	task automatic exec1(input logic [15:0] h);
		i_fetch_model.present(h);
		i_fetch_model.idle();
		checkResult(h);
		checkFlat();
	endtask

	task automatic load(input logic [2:0] idx, input logic [31:0] d);
		i_fetch_model.preload(idx, d);
		shadow[idx] = d;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic testShift();
		logic [15:0] t [8];
		t = '{f1(0, 0, 4, 0), f1(0, 1, 2, 1), f1(0, 31, 1, 3), f1(1, 0, 5, 2),
			f1(1, 27, 5, 2), f1(2, 0, 7, 6), f1(2, 4, 5, 4), f1(2, 31, 3, 7)};
		foreach (t[i]) exec1(t[i]);
		$display("test shift done");
	endtask

	task automatic testAddSub();
		load(3'h0, 32'h7fff_ffff);
		load(3'h1, 32'h0000_0001);
		load(3'h3, 32'hffff_ffff);
		exec1(f2(0, 0, 1, 0, 2));
		exec1(f2(1, 0, 7, 3, 4));
		exec1(f2(0, 1, 3, 3, 5));
		exec1(f2(0, 1, 0, 2, 7));
		exec1(f2(1, 1, 6, 1, 6));
		$display("test addsub done");
	endtask

	task automatic testByteOp();
		load(3'h2, 32'h0000_003e);
		exec1(f3(0, 0, 8'h80));
		exec1(f3(1, 2, 8'h3e));
		exec1(f3(1, 2, 8'hff));
		exec1(f3(2, 1, 8'hff));
		exec1(f3(3, 6, 8'h91));
		$display("test byteop done");
	endtask

	task automatic testOtherForms();
		logic [15:0] t [5];
		t = '{16'h4440, 16'h4640, 16'ha004, 16'hb004, 16'h4000};
		load(3'h7, 32'h8000_0000);
		exec1(f3(1, 7, 8'h00));
		foreach (t[i]) exec1(t[i]);
		$display("test other forms done");
	endtask

	task automatic testBackToBack();
		i_fetch_model.present(f2(0, 0, 1, 0, 0));
		i_fetch_model.present(f1(2, 1, 0, 0));
		checkResult(f2(0, 0, 1, 0, 0));
		i_fetch_model.present(f3(3, 0, 8'h05));
		checkResult(f1(2, 1, 0, 0));
		i_fetch_model.idle();
		checkResult(f3(3, 0, 8'h05));
		checkFlat();
		$display("test back to back done");
	endtask

	// a load beside an instruction loses the port; the other register must not move
	task automatic testLoadRefused();
		i_fetch_model.presentWithLoad(f3(0, 1, 8'h5a), 3'h2, 32'hdead_beef);
		checkResult(f3(0, 1, 8'h5a));
		checkFlat();
		$display("test load refused done");
	endtask

	// mid-run reset clears state; first request follows the post-reset state checks
	task automatic testReset();
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		foreach (shadow[i]) shadow[i] = compact_decode_pkg::REG_RESET;
		shadowFlags = compact_decode_pkg::FLAGS_RESET;
		@(negedge clock);
		compare("statusFlagsWord", 32'(shadowFlags), 32'(statusFlagsWord));
		compare("regWriteEn", 32'h0000_0000, 32'(regWriteEn));
		compare("instrDone", 32'h0000_0000, 32'(instrDone));
		checkFlat();
		exec1(f3(2, 3, 8'h11));
		$display("test reset done");
	endtask

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		n_errors    = 0;
		check_count = 0;
		shadowFlags = 4'h0;
		foreach (shadow[i]) shadow[i] = 32'h0000_0000;
		rst = 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		compare("statusFlagsWord", 32'(compact_decode_pkg::FLAGS_RESET), 32'(statusFlagsWord));
		for (int i = 0; i < 8; i++) begin
			load(3'(i), 32'h1357_9bdf * (i + 1) ^ 32'h8000_0000 * (i % 2));
		end
		testShift();
		testAddSub();
		testByteOp();
		testOtherForms();
		testBackToBack();
		testLoadRefused();
		testReset();
		end_sim();
	end

	// a hang is cut short and reported as a mismatch
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		$display("Error watchdog expected end seen hang");
		end_sim();
	end
endmodule
